// ===== amp_fault_regs.vh
// Purpose: Constants for the amplifier fault supervisor
// Assumes: 25 MHz system clock
// Notes:   Times in their own unit, cycle counts derived
`ifndef AMP_FAULT_REGS_VH
`define AMP_FAULT_REGS_VH

`define CLK_HZ            25000000
`define DC_TIMEOUT_MS     420
// Longest-time style: the fault needs strictly more than this many cycles
`define DC_TIMEOUT_CYC    ((`CLK_HZ / 1000) * `DC_TIMEOUT_MS)
// Duty excess threshold in percent of full scale from balance
`define DC_EXCESS_PCT     14
`define DUTY_HALF_PCT     50
// DC trip input levels in mV per gain code
`define TRIP_MV_G20       16'h0070
`define TRIP_MV_G26       16'h0038
`define TRIP_MV_G32       16'h001C
`define TRIP_MV_G36       16'h0011
// Gain codes, high select bit first
`define GAIN_20DB         2'h0
`define GAIN_26DB         2'h1
`define GAIN_32DB         2'h2
`define GAIN_36DB         2'h3
`define THERM_TRIP_C      150
`define THERM_HYST_C      15

`endif

// ===== amp_fault_supervisor.v
// Purpose: Fault supervision and bridge modulation for a mono BTL amp
// Assumes: Single 25 MHz clock; analog measurements arrive as digital
//          words from converters on the same clock
// Notes:   Bridge pins are modelled as level plus output enable
//
// Summary of operation
// - DC fault drives fault line low
// - DC fault tristates both bridge outputs
// - DC fault clears only on supply cycle
// - Excess beyond 14% over 420 ms trips
// - Trip input level follows selected gain
// - Output short sets latch, fault low
// - Short latch tristates both bridge outputs
// - Power-down low pulse clears short latch
// - Fault tied to power-down gives auto recovery from short only
// - Over-temperature shuts down and disables outputs
// - Thermal fault self-clears after 15 degree drop
// - Thermal shutdown never drives fault line
// - Legs switch rail to rail, in phase idle
// - Positive output widens positive leg duty
// - Power-down low mutes, low-current state
// - Gain select 00..11 gives 20..36 dB
`timescale 1ns/1ps
`include "amp_fault_regs.vh"

module amp_fault_supervisor #(
    parameter DW          = 8,
    parameter DC_TIMEOUT  = `DC_TIMEOUT_CYC
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          power_down_n,
    input  wire          gain_select_hi,
    input  wire          gain_select_lo,
    input  wire          power_stage_supply,
    input  wire          short_detect,
    input  wire [7:0]    die_temp_c,
    input  wire [DW-1:0] audio_level,
    input  wire [DW-1:0] pwm_count,
    output reg           bridge_pos_out,
    output reg           bridge_pos_oe,
    output reg           bridge_neg_out,
    output reg           bridge_neg_oe,
    output wire          fault_n_out,
    output wire          fault_n_oe,
    output reg  [1:0]    gain_code,
    output reg  [15:0]   dc_trip_mv,
    output wire          dc_fault,
    output wire          short_fault,
    output wire          thermal_shutdown,
    output wire          low_current
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Each of the five control pins gets its own two-stage chain; only stage two is read
    localparam NSYNC = 5;
    wire [NSYNC-1:0] pin_raw;
    wire [NSYNC-1:0] sync;
    assign pin_raw = {power_down_n, gain_select_hi, gain_select_lo,
                      power_stage_supply, short_detect};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            reg meta_q;
            reg sync_q;
            always @(posedge clk) begin
                if (rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else begin
                    meta_q <= pin_raw[gi];
                    sync_q <= meta_q;
                end
            end
            assign sync[gi] = sync_q;
        end
    endgenerate

    wire pd_n   = sync[4];
    wire g_hi   = sync[3];
    wire g_lo   = sync[2];
    wire supply = sync[1];
    wire shrt   = sync[0];

    // ----------------------------------------------------------------
    // Gain selection
    // ----------------------------------------------------------------
    reg [15:0] next_trip_mv;
    always @* begin
        case ({g_hi, g_lo})
            `GAIN_20DB: next_trip_mv = `TRIP_MV_G20;
            `GAIN_26DB: next_trip_mv = `TRIP_MV_G26;
            `GAIN_32DB: next_trip_mv = `TRIP_MV_G32;
            `GAIN_36DB: next_trip_mv = `TRIP_MV_G36;
            default:    next_trip_mv = `TRIP_MV_G20;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            gain_code  <= `GAIN_20DB;
            dc_trip_mv <= `TRIP_MV_G20;
        end else begin
            gain_code  <= {g_hi, g_lo};
            dc_trip_mv <= next_trip_mv;
        end
    end

    // ----------------------------------------------------------------
    // Thermal shutdown with hysteresis, never latched
    // ----------------------------------------------------------------
    // The die word is already on this clock, so it is not synchronised
    reg therm;
    reg next_therm;
    always @* begin
        next_therm = therm;
        if (!therm && die_temp_c > `THERM_TRIP_C)
            next_therm = 1'b1;
        else if (therm &&
                 die_temp_c <= (`THERM_TRIP_C - `THERM_HYST_C))
            next_therm = 1'b0;
    end

    always @(posedge clk) begin
        if (rst)
            therm <= 1'b0;
        else
            therm <= next_therm;
    end
    assign thermal_shutdown = therm;

    // ----------------------------------------------------------------
    // PWM carrier and leg comparators
    // ----------------------------------------------------------------
    // Legs share one carrier so a mid-scale word keeps them in phase
    wire [DW-1:0] neg_level = ~audio_level;
    wire          run_bridge;
    reg  [DW-1:0] carrier;
    reg           next_pos_out;
    reg           next_neg_out;

    always @(posedge clk) begin
        if (rst)
            carrier <= {DW{1'b0}};
        else
            carrier <= carrier + 1'b1;
    end

    always @* begin
        // Wider positive leg when audio above mid-scale
        next_pos_out = run_bridge && (carrier < audio_level);
        next_neg_out = run_bridge && (carrier < neg_level);
    end

    always @(posedge clk) begin
        if (rst) begin
            bridge_pos_out <= 1'b0;
            bridge_neg_out <= 1'b0;
            bridge_pos_oe  <= 1'b0;
            bridge_neg_oe  <= 1'b0;
        end else begin
            bridge_pos_out <= next_pos_out;
            bridge_neg_out <= next_neg_out;
            bridge_pos_oe  <= run_bridge;
            bridge_neg_oe  <= run_bridge;
        end
    end

    // ----------------------------------------------------------------
    // Differential duty measurement over one carrier period
    // ----------------------------------------------------------------
    // Excess in carrier counts: diff duty > 14% of the period
    localparam [DW:0] EXCESS_TH =
        ((1 << DW) * `DC_EXCESS_PCT) / 100;
    reg  [DW:0] high_p;
    reg  [DW:0] high_n;
    reg         pol_pos;
    reg         over;
    reg         period_end;
    reg  [DW:0] next_high_p;
    reg  [DW:0] next_high_n;
    reg         next_pol_pos;
    reg         next_over;
    wire        last = (carrier == {DW{1'b1}});

    // The verdict lags by one period; a short burst cannot trip it
    always @* begin
        next_high_p  = high_p + {{DW{1'b0}}, bridge_pos_out};
        next_high_n  = high_n + {{DW{1'b0}}, bridge_neg_out};
        next_pol_pos = pol_pos;
        next_over    = over;
        if (last) begin
            next_high_p = {(DW+1){1'b0}};
            next_high_n = {(DW+1){1'b0}};
            if (high_p > high_n) begin
                next_over    = (high_p - high_n) > EXCESS_TH;
                next_pol_pos = 1'b1;
            end else begin
                next_over    = (high_n - high_p) > EXCESS_TH;
                next_pol_pos = 1'b0;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            high_p     <= {(DW+1){1'b0}};
            high_n     <= {(DW+1){1'b0}};
            pol_pos    <= 1'b0;
            over       <= 1'b0;
            period_end <= 1'b0;
        end else begin
            high_p     <= next_high_p;
            high_n     <= next_high_n;
            pol_pos    <= next_pol_pos;
            over       <= next_over;
            period_end <= last && run_bridge;
        end
    end

    // ----------------------------------------------------------------
    // DC detect timer and latch
    // ----------------------------------------------------------------
    reg [31:0] dc_cnt;
    reg        last_pol;
    reg        dc_latch;
    reg [31:0] next_dc_cnt;
    reg        next_last_pol;
    reg        next_dc_latch;

    always @* begin
        next_dc_cnt   = dc_cnt;
        next_last_pol = last_pol;
        next_dc_latch = dc_latch;
        if (!supply) begin
            // Only removing the stage supply clears it
            next_dc_latch = 1'b0;
            next_dc_cnt   = 32'h0000_0000;
        end else if (!run_bridge || !over ||
                     (period_end && pol_pos != last_pol)) begin
            next_dc_cnt   = 32'h0000_0000;
            next_last_pol = pol_pos;
        end else if (dc_cnt > DC_TIMEOUT) begin
            next_dc_latch = 1'b1;
        end else begin
            next_dc_cnt = dc_cnt + 32'h0000_0001;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            dc_cnt   <= 32'h0000_0000;
            last_pol <= 1'b0;
            dc_latch <= 1'b0;
        end else begin
            dc_cnt   <= next_dc_cnt;
            last_pol <= next_last_pol;
            dc_latch <= next_dc_latch;
        end
    end
    assign dc_fault = dc_latch;

    // ----------------------------------------------------------------
    // Short-circuit latch
    // ----------------------------------------------------------------
    // Set and clear never meet: a set needs power-down high
    reg sc_latch;
    reg next_sc_latch;
    always @* begin
        next_sc_latch = sc_latch;
        if (shrt && pd_n && supply)
            next_sc_latch = 1'b1;
        else if (!pd_n)
            // Low on power-down clears; fault tied back auto-recovers
            next_sc_latch = 1'b0;
    end

    always @(posedge clk) begin
        if (rst)
            sc_latch <= 1'b0;
        else
            sc_latch <= next_sc_latch;
    end
    assign short_fault = sc_latch;

    // ----------------------------------------------------------------
    // Output control and fault line
    // ----------------------------------------------------------------
    // Power-down mutes; any latch or thermal trip tristates the legs
    assign run_bridge = pd_n && supply && !therm
                        && !dc_latch
                        && !sc_latch;
    assign low_current = !pd_n;
    // Open drain: thermal state deliberately left out
    assign fault_n_out = 1'b0;
    assign fault_n_oe  = dc_latch | sc_latch;

endmodule

// ===== fault_checker.sv
// Purpose: Port assertions for the amplifier fault supervisor
// Assumes: Pins pass two sync stages before the logic sees them
// Notes:   Bound into every supervisor instance
`timescale 1ns/1ps
module fault_checker (
    input wire        clk, rst, power_down_n, power_stage_supply,
    input wire        gain_select_hi, gain_select_lo, short_detect,
    input wire [7:0]  die_temp_c,
    input wire        bridge_pos_oe, bridge_neg_oe, fault_n_out,
    input wire        fault_n_oe, dc_fault, short_fault,
    input wire        thermal_shutdown, low_current,
    input wire [1:0]  gain_code,
    input wire [15:0] dc_trip_mv
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire        hiz = !bridge_pos_oe && !bridge_neg_oe;
    wire        lat = dc_fault || short_fault;
    wire [1:0]  gs  = {gain_select_hi, gain_select_lo};
    wire [15:0] mv  = gs[1] ? (gs[0] ? 16'h0011 : 16'h001c)
                            : (gs[0] ? 16'h0038 : 16'h0070);
    // Windows cover the sync latency so no attempt fires early
    sequence short_s;
        (short_detect && power_down_n && power_stage_supply) [*5];
    endsequence
    sequence held_s;
        power_stage_supply [*4] ##0 dc_fault;
    endsequence
    fault_drive_a: assert property (fault_n_oe == lat)
        else $error("fault line disagrees with latches");
    fault_low_a: assert property (fault_n_oe |-> !fault_n_out)
        else $error("fault line driven high");
    off_hiz_a: assert property (lat || thermal_shutdown |=> hiz)
        else $error("bridge driven during fault");
    dc_hold_a: assert property (held_s |=> dc_fault)
        else $error("dc latch lost with supply up");
    short_set_a: assert property (short_s |-> ##[0:1] short_fault)
        else $error("short not latched");
    short_clr_a: assert property (!power_down_n [*4] |=> !short_fault)
        else $error("short latch not cleared");
    therm_set_a: assert property (die_temp_c > 8'h96 |=> thermal_shutdown)
        else $error("hot die not shut down");
    mute_a: assert property (!power_down_n [*3] |=> hiz && low_current)
        else $error("power-down did not mute");
    gain_map_a: assert property ($stable(gs) [*6] |->
        gain_code == gs && dc_trip_mv == mv) else $error("gain map wrong");
endmodule
bind amp_fault_supervisor fault_checker chk (.*);

// ===== sys_ctrl_model.sv
// Purpose: System controller on the far side of the supervisor
// Assumes: Fault line is open drain with a pull-up
// Notes:   Auto mode wires the fault line to power-down
`timescale 1ns/1ps
module sys_ctrl_model #(parameter SETTLE = 8'h14) (
    input  wire clk, rst, auto, run_req, fault_n_out, fault_n_oe,
    output wire fault_line,
    output reg  power_down_n = 1'b0
);
    reg [7:0] settle = 8'h00;
    // Pull-up wins whenever the supervisor lets go
    assign fault_line = fault_n_oe ? fault_n_out : 1'b1;
    always @(posedge clk) begin
        settle <= rst ? 8'h00 : settle + {7'h00, settle != SETTLE};
        // Kept low after power-up so unsettled inputs cannot trip
        power_down_n <= !rst && settle == SETTLE
            && (auto ? fault_line : run_req);
    end
endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the amplifier fault supervisor
// Assumes: Controller model drives power-down and the fault line
// Notes:   DC timeout shortened to 1000 cycles
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0, rst = 1'b1, auto = 1'b0, run_req = 1'b0;
    logic        power_stage_supply = 1'b1, short_detect = 1'b0, hot = 1'b0;
    logic        gain_select_hi = 1'b0, gain_select_lo = 1'b0;
    logic [7:0]  die_temp_c = 8'h19, audio_level = 8'h80, pwm_count = 8'h00;
    wire         power_down_n, fault_line, fault_n_out, fault_n_oe;
    wire         bridge_pos_out, bridge_pos_oe, bridge_neg_out, bridge_neg_oe;
    wire         dc_fault, short_fault, thermal_shutdown, low_current;
    wire [1:0]   gain_code;
    wire [15:0]  dc_trip_mv;
    wire [6:0]   st = {fault_line, bridge_pos_oe, bridge_neg_oe, low_current,
                       dc_fault, short_fault, thermal_shutdown};
    logic [31:0] rnd = 32'h0000_0037;
    logic [7:0]  temp_set = 8'h96;
    logic [25:0] exp_q[$];
    logic [25:0] e;
    logic [15:0] tt[4] = '{16'h0070, 16'h0038, 16'h001c, 16'h0011};
    int          err_count = 0, checks = 0, pc, nc;
    amp_fault_supervisor #(.DC_TIMEOUT(1000)) DUT (.*);
    sys_ctrl_model CTRL (.*);
    always #20 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        return v ^ (v << 5);
    endfunction
    // Random spare word and a cool die keep idle inputs moving
    always @(posedge clk) begin
        rnd <= xs(rnd);
        pwm_count <= rnd[7:0];
        die_temp_c <= hot ? temp_set : {1'b0, rnd[14:8]};
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic ex(input logic [1:0] k, input logic [23:0] v);
        exp_q.push_back({k, v});
    endtask
    task automatic es(input logic [6:0] v);
        ex(2'h0, {17'h0_0000, v});
    endtask
    always @(negedge clk)
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            check(e[25:24] == 2'h0 ? {17'h0_0000, st} : e[25:24] == 2'h1 ?
                  {6'h00, gain_code, dc_trip_mv} : {pc[11:0], nc[11:0]},
                  e[23:0]);
        end
    task automatic conclude;
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic duty;
        pc = 0;
        nc = 0;
        repeat (256) begin
            @(negedge clk);
            pc += bridge_pos_out;
            nc += bridge_neg_out;
        end
    endtask
    initial begin
        cyc(3);
        rst <= 1'b0;
        cyc(2);
        es(7'h48);
        for (int g = 0; g < 4; g++) begin
            gain_select_hi <= g[1];
            gain_select_lo <= g[0];
            cyc(7);
            ex(2'h1, {6'h00, g[1:0], tt[g]});
        end
        run_req <= 1'b1;
        cyc(12);
        es(7'h70);
        duty;
        ex(2'h2, 24'h08_007f);
        audio_level <= 8'hc0;
        cyc(256);
        duty;
        ex(2'h2, 24'h0c_003f);
        // Polarity flips inside the timeout must never trip
        for (int k = 0; k < 4; k++) begin
            audio_level <= k[0] ? 8'hc0 : 8'h40;
            cyc(700);
        end
        es(7'h70);
        audio_level <= 8'h91;
        cyc(1600);
        es(7'h70);
        audio_level <= 8'h40;
        cyc(900);
        es(7'h70);
        for (int i = 0; i < 1000 && dc_fault !== 1'b1; i++) cyc(1);
        if (dc_fault !== 1'b1) err_count++;
        cyc(2);
        es(7'h04);
        run_req <= 1'b0;
        cyc(8);
        run_req <= 1'b1;
        cyc(8);
        es(7'h04);
        power_stage_supply <= 1'b0;
        audio_level <= 8'h80;
        cyc(6);
        power_stage_supply <= 1'b1;
        cyc(8);
        es(7'h70);
        short_detect <= 1'b1;
        cyc(5);
        es(7'h02);
        run_req <= 1'b0;
        cyc(8);
        es(7'h48);
        short_detect <= 1'b0;
        run_req <= 1'b1;
        cyc(8);
        es(7'h70);
        auto <= 1'b1;
        short_detect <= 1'b1;
        cyc(2);
        short_detect <= 1'b0;
        cyc(30);
        es(7'h70);
        auto <= 1'b0;
        hot <= 1'b1;
        cyc(1);
        temp_set <= 8'h96;
        cyc(3);
        es(7'h70);
        temp_set <= 8'h97;
        cyc(3);
        es(7'h41);
        temp_set <= 8'h88;
        cyc(4);
        es(7'h41);
        temp_set <= 8'h87;
        cyc(4);
        es(7'h70);
        cyc(2);
        conclude;
    end
endmodule
